// file: src/mgc_pkg.sv
package mgc_pkg;
   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_SETTINGS   = 4'h1;
   localparam logic [3:0] IDX_INT_SETPT  = 4'h5;
   localparam logic [3:0] IDX_FRAC_MSB   = 4'h6;
   localparam logic [3:0] IDX_FRAC_LSB   = 4'h7;
   localparam logic [3:0] IDX_PIN_CFG    = 4'h8;
   localparam logic [3:0] IDX_COMP_ADDR  = 4'h9;
   localparam logic [3:0] IDX_SEED_UP    = 4'hA;
   localparam logic [3:0] IDX_SEED_LO    = 4'hB;
   localparam logic [3:0] IDX_DSTEP_UP   = 4'hC;
   localparam logic [3:0] IDX_DSTEP_LO   = 4'hD;
   localparam logic [3:0] IDX_MOD_CFG    = 4'hE;
   localparam logic [3:0] IDX_STATUS     = 4'hF;
   localparam int         IDX_LSB        = 2;
   localparam int         IDX_W          = 4;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int UP_W   = 30;
   localparam int LO_W   = 18;
   localparam int PIN_W  = 14;
   localparam int CFG_W  = 12;
   localparam int SET_W  = 10;
   localparam int INT_W  = 20;
   localparam int NPINS  = 5;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [SET_W-1:0] RST_SETTINGS = 10'h3FD;
   localparam logic [INT_W-1:0] RST_INT      = 20'h000C8;
   localparam logic [PIN_W-1:0] RST_PIN_CFG  = 14'h3E00;
   localparam logic [2:0]       RST_COMP     = 3'h2;
   localparam logic [UP_W-1:0]  RST_SEED_UP  = 30'h00004241;
   localparam logic [LO_W-1:0]  RST_SEED_LO  = 18'h10081;
   localparam logic [CFG_W-1:0] RST_MOD_CFG  = 12'h173;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SET_GPIO_EN   = 4;
   localparam int PIN_SEL_LSB   = 0;
   localparam int PIN_SEL_W     = 4;
   localparam int PIN_TST_LSB   = 4;
   localparam int PIN_DIR_LSB   = 9;
   localparam int CFG_TYPE_LSB  = 0;
   localparam int CFG_RPT_CTL   = 2;
   localparam int CFG_RPT_ON    = 3;
   localparam int CFG_DLY_LSB   = 4;
   localparam int CFG_START_DLY = 7;
   localparam int CFG_AUTOSEED  = 8;
   localparam int CFG_PHASE     = 9;
   localparam int CFG_KEEP      = 10;
   localparam int CFG_SWEEP     = 11;

   // modulator type codes
   typedef enum logic [1:0] {
      MGC_MOD_RSV0 = 2'h0,
      MGC_MOD_RSV1 = 2'h1,
      MGC_MOD_B    = 2'h2,
      MGC_MOD_A    = 2'h3
   } mgc_mod_t;

   localparam logic [2:0] DLY_AUTO = 3'h7;
endpackage : mgc_pkg

// file: src/mgc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module mgc_sync #(
   parameter int W = 5
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;     // first stage, read only by q

   // ---------------------------------------------------------------
   // double flop
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : mgc_sync

// file: src/mgc_delay_cnt.sv
`timescale 1ns/1ps
// loadable down counter: busy while counting, done pulse at end
module mgc_delay_cnt #(
   parameter int W = 20
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         start,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_r;      // remaining cycles

   // ---------------------------------------------------------------
   // count down from load value
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            cnt_r <= count;
            busy  <= 1'b1;
         end else if (busy) begin
            if (cnt_r == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule : mgc_delay_cnt

// file: src/mgc_regs.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// How it works
// - four-bit output select, resets zero
// - pin controls act only with master enable
// - five-bit static test value drives pins
// - per-pin direction bits, reset all outputs
// - companion chip address, reset two
// - seed split 30/18, documented resets
// - down step count split, resets zero
// - modulator type, reserved codes unused
// - repeat only when both repeat bits set
// - integer path delay field, reset automatic
// - start delay postpones sweep start
// - autoseed reloads seed on setpoint change
// - phase step needs autoseed cleared
// - each upper seed write applies shift
// - keep accumulator state within integer
// - bit 11 enables sweep mode
// - integer setpoint doubles as delay count
// - asymmetric down sweep uses down registers
module mgc_regs (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [4:0]  gpio_in,
   input  wire logic [4:0]  export_data,
   input  wire logic        frac_changed,
   input  wire logic        sweep_end,
   input  wire logic        sweep_start_req,
   input  wire logic        symmetric_sweep,
   output logic      [4:0]  gpio_out,
   output logic      [4:0]  gpio_oe,
   output logic      [3:0]  export_select,
   output logic      [2:0]  companion_addr,
   output logic      [47:0] accumulator_seed,
   output logic      [47:0] down_step_count,
   output logic      [47:0] active_down_steps,
   output logic      [1:0]  modulator_type,
   output logic      [2:0]  int_path_delay,
   output logic             keep_state,
   output logic             sweep_mode,
   output logic             seed_reload,
   output logic             phase_step_pulse,
   output logic             sweep_restart,
   output logic             sweep_go
);
   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [mgc_pkg::SET_W-1:0] settings_r;   // gpio master enable etc
   logic [mgc_pkg::INT_W-1:0] int_setpt_r;  // integer / delay count
   logic [mgc_pkg::UP_W-1:0]  frac_up_r;    // fractional upper
   logic [mgc_pkg::LO_W-1:0]  frac_lo_r;    // fractional lower
   logic [mgc_pkg::PIN_W-1:0] pin_cfg_r;    // pin configuration
   logic [2:0]                comp_r;       // companion address
   logic [mgc_pkg::UP_W-1:0]  seed_up_r;    // seed upper
   logic [mgc_pkg::LO_W-1:0]  seed_lo_r;    // seed lower
   logic [mgc_pkg::UP_W-1:0]  dstep_up_r;   // down steps upper
   logic [mgc_pkg::LO_W-1:0]  dstep_lo_r;   // down steps lower
   logic [mgc_pkg::CFG_W-1:0] mod_cfg_r;    // modulator config
   logic                      ack_r;        // bus acknowledge
   logic                      pstep_r;      // phase step pulse
   logic                      reload_r;     // seed reload pulse
   logic                      rpt_r;        // restart pulse
   logic [31:0]               rdata;        // read mux
   logic                      wr_en;        // write strobe
   logic [mgc_pkg::IDX_W-1:0] idx;          // register index
   logic [4:0]                pins_sync;    // synchronised pin levels
   logic                      dly_busy;     // start delay running
   logic                      dly_done;     // start delay finished
   logic                      master_en;    // gpio master enable

   // merge a 32-bit write into a register under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction : merge

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign idx   = wb_adr_i[mgc_pkg::IDX_LSB +: mgc_pkg::IDX_W];
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

   // ack one cycle after request, dropped the next cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) ack_r <= 1'b0;
      else         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
   end
   assign wb_ack_o = ack_r;

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         settings_r  <= mgc_pkg::RST_SETTINGS;
         int_setpt_r <= mgc_pkg::RST_INT;
         frac_up_r   <= '0;
         frac_lo_r   <= '0;
         pin_cfg_r   <= mgc_pkg::RST_PIN_CFG;
         comp_r      <= mgc_pkg::RST_COMP;
         seed_up_r   <= mgc_pkg::RST_SEED_UP;
         seed_lo_r   <= mgc_pkg::RST_SEED_LO;
         dstep_up_r  <= '0;
         dstep_lo_r  <= '0;
         mod_cfg_r   <= mgc_pkg::RST_MOD_CFG;
      end else if (wr_en) begin
         unique case (idx)
            mgc_pkg::IDX_SETTINGS: settings_r <= mgc_pkg::SET_W'(
               merge(32'(settings_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_INT_SETPT: int_setpt_r <= mgc_pkg::INT_W'(
               merge(32'(int_setpt_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_FRAC_MSB: frac_up_r <= mgc_pkg::UP_W'(
               merge(32'(frac_up_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_FRAC_LSB: frac_lo_r <= mgc_pkg::LO_W'(
               merge(32'(frac_lo_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_PIN_CFG: pin_cfg_r <= mgc_pkg::PIN_W'(
               merge(32'(pin_cfg_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_COMP_ADDR: comp_r <= 3'(
               merge(32'(comp_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_SEED_UP: seed_up_r <= mgc_pkg::UP_W'(
               merge(32'(seed_up_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_SEED_LO: seed_lo_r <= mgc_pkg::LO_W'(
               merge(32'(seed_lo_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_DSTEP_UP: dstep_up_r <= mgc_pkg::UP_W'(
               merge(32'(dstep_up_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_DSTEP_LO: dstep_lo_r <= mgc_pkg::LO_W'(
               merge(32'(dstep_lo_r), wb_dat_i, wb_sel_i));
            mgc_pkg::IDX_MOD_CFG: mod_cfg_r <= mgc_pkg::CFG_W'(
               merge(32'(mod_cfg_r), wb_dat_i, wb_sel_i));
            default: ;   // unmapped and read-only: ignored
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rdata = '0;
      unique case (idx)
         mgc_pkg::IDX_SETTINGS:  rdata = 32'(settings_r);
         mgc_pkg::IDX_INT_SETPT: rdata = 32'(int_setpt_r);
         mgc_pkg::IDX_FRAC_MSB:  rdata = 32'(frac_up_r);
         mgc_pkg::IDX_FRAC_LSB:  rdata = 32'(frac_lo_r);
         mgc_pkg::IDX_PIN_CFG:   rdata = 32'(pin_cfg_r);
         mgc_pkg::IDX_COMP_ADDR: rdata = 32'(comp_r);
         mgc_pkg::IDX_SEED_UP:   rdata = 32'(seed_up_r);
         mgc_pkg::IDX_SEED_LO:   rdata = 32'(seed_lo_r);
         mgc_pkg::IDX_DSTEP_UP:  rdata = 32'(dstep_up_r);
         mgc_pkg::IDX_DSTEP_LO:  rdata = 32'(dstep_lo_r);
         mgc_pkg::IDX_MOD_CFG:   rdata = 32'(mod_cfg_r);
         mgc_pkg::IDX_STATUS:    rdata = {25'h0, dly_busy, 1'b0,
                                          pins_sync};
         default:                rdata = '0;   // unmapped reads zero
      endcase
   end

   // read data registered on request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) wb_dat_o <= '0;
      else if (wb_cyc_i && wb_stb_i && !ack_r) wb_dat_o <= rdata;
   end

   // ---------------------------------------------------------------
   // gpio pins
   // ---------------------------------------------------------------
   mgc_sync #(.W(mgc_pkg::NPINS)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (gpio_in),
      .q      (pins_sync)
   );

   assign master_en = settings_r[mgc_pkg::SET_GPIO_EN];

   // select, test value and direction gated by master enable
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gpio_out      <= '0;
         gpio_oe       <= '0;
         export_select <= '0;
      end else if (master_en) begin
         export_select <= pin_cfg_r[mgc_pkg::PIN_SEL_LSB +:
                                    mgc_pkg::PIN_SEL_W];
         gpio_oe  <= pin_cfg_r[mgc_pkg::PIN_DIR_LSB +:
                               mgc_pkg::NPINS];
         gpio_out <= (pin_cfg_r[mgc_pkg::PIN_SEL_LSB +:
                                mgc_pkg::PIN_SEL_W] == '0)
                     ? pin_cfg_r[mgc_pkg::PIN_TST_LSB +:
                                 mgc_pkg::NPINS]
                     : export_data;
      end else begin
         gpio_out      <= '0;
         gpio_oe       <= '0;
         export_select <= '0;
      end
   end

   // ---------------------------------------------------------------
   // modulator configuration outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         companion_addr    <= mgc_pkg::RST_COMP;
         accumulator_seed  <= '0;
         down_step_count   <= '0;
         active_down_steps <= '0;
         modulator_type    <= mgc_pkg::MGC_MOD_A;
         int_path_delay    <= mgc_pkg::DLY_AUTO;
         keep_state        <= 1'b0;
         sweep_mode        <= 1'b0;
      end else begin
         companion_addr   <= comp_r;
         accumulator_seed <= {seed_up_r, seed_lo_r};
         down_step_count  <= {dstep_up_r, dstep_lo_r};
         // asymmetric down sweep uses its own step count
         active_down_steps <= symmetric_sweep
                              ? {frac_up_r, frac_lo_r}
                              : {dstep_up_r, dstep_lo_r};
         // reserved codes never reach the modulator
         if (mod_cfg_r[mgc_pkg::CFG_TYPE_LSB +: 2] == mgc_pkg::MGC_MOD_B ||
             mod_cfg_r[mgc_pkg::CFG_TYPE_LSB +: 2] == mgc_pkg::MGC_MOD_A)
            modulator_type <= mod_cfg_r[mgc_pkg::CFG_TYPE_LSB +: 2];
         int_path_delay <= mod_cfg_r[mgc_pkg::CFG_DLY_LSB +: 3];
         keep_state     <= mod_cfg_r[mgc_pkg::CFG_KEEP];
         sweep_mode     <= mod_cfg_r[mgc_pkg::CFG_SWEEP];
      end
   end

   // ---------------------------------------------------------------
   // seed reload and phase step pulses
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reload_r <= 1'b0;
         pstep_r  <= 1'b0;
      end else begin
         reload_r <= frac_changed &&
                     mod_cfg_r[mgc_pkg::CFG_AUTOSEED];
         // phase step only honoured with autoseed off
         pstep_r  <= wr_en && idx == mgc_pkg::IDX_SEED_UP &&
                     mod_cfg_r[mgc_pkg::CFG_PHASE] &&
                     !mod_cfg_r[mgc_pkg::CFG_AUTOSEED];
      end
   end
   assign seed_reload      = reload_r;
   assign phase_step_pulse = pstep_r;

   // ---------------------------------------------------------------
   // sweep repeat and delayed start
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) rpt_r <= 1'b0;
      else rpt_r <= sweep_end && mod_cfg_r[mgc_pkg::CFG_RPT_CTL] &&
                    mod_cfg_r[mgc_pkg::CFG_RPT_ON];
   end
   assign sweep_restart = rpt_r;

   // integer setpoint is the delay count in sweep mode
   mgc_delay_cnt #(.W(mgc_pkg::INT_W)) u_dly (
      .clk    (clk),
      .resetn (resetn),
      .start  (sweep_start_req && sweep_mode &&
               mod_cfg_r[mgc_pkg::CFG_START_DLY]),
      .count  (int_setpt_r),
      .busy   (dly_busy),
      .done   (dly_done)
   );

   // immediate start, or postponed by the delay count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) sweep_go <= 1'b0;
      else sweep_go <= mod_cfg_r[mgc_pkg::CFG_START_DLY]
                       ? dly_done
                       : (sweep_start_req && sweep_mode);
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // ack is a single-cycle pulse, never held
   a_ack_single: assert property (@(posedge clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
   // two cycles without master enable leave every pin undriven
   a_pins_gated: assert property (
      @(posedge clk) disable iff (!resetn)
      !master_en ##1 !master_en |-> gpio_oe == '0)
      else $error("pins driven without master enable");
   // directions follow one cycle later; reset edge itself excluded
   a_dir_follow: assert property (
      @(posedge clk) disable iff (!resetn)
      resetn && master_en |=>
         gpio_oe == $past(pin_cfg_r[mgc_pkg::PIN_DIR_LSB +: mgc_pkg::NPINS]))
      else $error("direction not applied");
   // a step pulse needs phase enable with autoseed off
   a_phase_step: assert property (
      @(posedge clk) disable iff (!resetn)
      phase_step_pulse |-> !$past(mod_cfg_r[mgc_pkg::CFG_AUTOSEED]) &&
                           $past(mod_cfg_r[mgc_pkg::CFG_PHASE]))
      else $error("phase step without enable");
   // every honoured upper seed write yields one step pulse
   a_phase_each: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_en && idx == mgc_pkg::IDX_SEED_UP &&
      mod_cfg_r[mgc_pkg::CFG_PHASE] && !mod_cfg_r[mgc_pkg::CFG_AUTOSEED]
      |=> phase_step_pulse)
      else $error("phase step missing after seed write");
   // restart only when both repeat bits were set
   a_repeat_both: assert property (
      @(posedge clk) disable iff (!resetn)
      sweep_restart |-> $past(mod_cfg_r[mgc_pkg::CFG_RPT_CTL]) &&
                        $past(mod_cfg_r[mgc_pkg::CFG_RPT_ON]))
      else $error("repeat without both bits");
   // set point change with autoseed on reloads the seed
   a_reload_auto: assert property (
      @(posedge clk) disable iff (!resetn)
      frac_changed && mod_cfg_r[mgc_pkg::CFG_AUTOSEED] |=> seed_reload)
      else $error("seed not reloaded");
   // reserved codes never reach the modulator
   a_type_legal: assert property (
      @(posedge clk) disable iff (!resetn)
      modulator_type[1])
      else $error("reserved modulator type used");
   // a legal code is forwarded one cycle later
   a_type_follow: assert property (
      @(posedge clk) disable iff (!resetn)
      resetn && mod_cfg_r[mgc_pkg::CFG_TYPE_LSB + 1] |=>
         modulator_type == $past(mod_cfg_r[mgc_pkg::CFG_TYPE_LSB +: 2]))
      else $error("legal modulator type not applied");
   // seed halves joined upper over lower; reset edge excluded
   a_seed_join: assert property (
      @(posedge clk) disable iff (!resetn)
      resetn |=> accumulator_seed == $past({seed_up_r, seed_lo_r}))
      else $error("seed halves misplaced");
   c_phase: cover property (@(posedge clk) phase_step_pulse);
   c_repeat: cover property (@(posedge clk) sweep_restart);
   c_delay: cover property (@(posedge clk) dly_done);
   c_type_b: cover property (@(posedge clk)
      modulator_type == mgc_pkg::MGC_MOD_B);
endmodule : mgc_regs

// file: tb/modulator_gpio_config_regs_bench.sv
`timescale 1ns/1ps
module modulator_gpio_config_regs_bench;
   // ------------------------------------------------------------
   // stimulus and observation signals
   // ------------------------------------------------------------
   logic        clk, resetn, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [3:0]  sel, exp_sel;
   logic [4:0]  gin, xdat, gout, goe;
   logic [2:0]  ev, caddr, pdly;
   logic [1:0]  mtype;
   logic [47:0] seed, dstep, adown;
   logic        keep, swp, rld, phs, rst, go, sym;
   int          mismatches, total_checks, seed_v, cyc_n;
   int          n_rld, n_phs, n_rst, n_go;
   logic [31:0] shadow [16];
   mgc_regs dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .gpio_in(gin),
      .export_data(xdat), .frac_changed(ev[0]), .sweep_end(ev[1]),
      .sweep_start_req(ev[2]), .symmetric_sweep(sym), .gpio_out(gout),
      .gpio_oe(goe), .export_select(exp_sel), .companion_addr(caddr),
      .accumulator_seed(seed), .down_step_count(dstep),
      .active_down_steps(adown), .modulator_type(mtype),
      .int_path_delay(pdly), .keep_state(keep), .sweep_mode(swp),
      .seed_reload(rld), .phase_step_pulse(phs), .sweep_restart(rst),
      .sweep_go(go));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // pulse counters and hang guard
   always @(posedge clk) begin
      n_rld += (rld === 1'b1);
      n_phs += (phs === 1'b1);
      n_rst += (rst === 1'b1);
      n_go  += (go === 1'b1);
      cyc_n++;
      if (cyc_n == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // classic cycle: hold until ack sampled, then release
   task automatic bus(input logic w, input logic [3:0] i,
                      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hF;
      adr <= {2'h0, i, 2'h0}; wdat <= d;
      // only the cycle ceiling ends a wait for ack
      do
         @(posedge clk);
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      if (w) shadow[i] = d;
   endtask : bus
   task automatic rd(input logic [3:0] i, input logic [31:0] e);
      bus(1'b0, i, 32'h0);
      chk({16'h0, q}, {16'h0, e});
   endtask : rd
   task automatic pulse(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev <= 3'h0;
      repeat (6) @(posedge clk);
   endtask : pulse
   function automatic logic [31:0] mask(input logic [3:0] i);
      case (i)
         4'h8: mask = 32'h3FFF;
         4'h9: mask = 32'h7;
         4'hA, 4'hC: mask = 32'h3FFFFFFF;
         default: mask = 32'h3FFFF;
      endcase
   endfunction : mask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] d;
      seed_v = 48;
      {resetn, cyc, stb, we, adr, wdat, sel, ev, sym} = '0;
      gin = 5'h15; xdat = 5'h0A;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h8, 32'h3E00); rd(4'h9, 32'h2);
      rd(4'hA, 32'h4241); rd(4'hB, 32'h10081);
      rd(4'hC, 32'h0); rd(4'hD, 32'h0);
      rd(4'hE, 32'h173);
      rd(4'hF, 32'h15);  // status shows synchronised pin levels
      chk(dstep, 48'h0);
      chk(seed, {30'h4241, 18'h10081});
      bus(1'b1, 4'h3, 32'hFFFF); rd(4'h3, 32'h0);  // unmapped index
      // random writes and read-back with forwarded outputs
      for (int k = 0; k < 30; k++) begin
         d = $random(seed_v);
         bus(1'b1, 4'h9 + 4'(k % 5), d);
         rd(4'h9 + 4'(k % 5), d & mask(4'h9 + 4'(k % 5)));
      end
      chk(caddr, shadow[9][2:0]);
      chk(seed, {shadow[10][29:0], shadow[11][17:0]});
      chk(dstep, {shadow[12][29:0], shadow[13][17:0]});
      chk(adown, {shadow[12][29:0], shadow[13][17:0]});
      // symmetric sweep reuses the set-point pair instead
      bus(1'b1, 4'h6, 32'h2AAAAAAA); bus(1'b1, 4'h7, 32'h15555);
      sym <= 1'b1;
      repeat (2) @(posedge clk);
      chk(adown, {30'h2AAAAAAA, 18'h15555});
      sym <= 1'b0;
      // pins: static test value and directions under master enable
      d = $random(seed_v);
      bus(1'b1, 4'h8, {18'h0, d[13:4], 4'h0});
      repeat (2) @(posedge clk);
      chk(gout, d[8:4]); chk(goe, d[13:9]);
      bus(1'b1, 4'h8, {18'h0, d[13:4], 4'h5});
      repeat (2) @(posedge clk);
      chk(exp_sel, 4'h5); chk(gout, xdat);
      bus(1'b1, 4'h1, 32'h3ED);
      repeat (2) @(posedge clk);
      chk({gout, goe}, 10'h0);
      bus(1'b1, 4'h1, 32'h3FD);
      // modulator type codes, reserved code not forwarded
      // outputs settle one cycle after the write: look mid-cycle
      bus(1'b1, 4'hE, 32'h172); @(negedge clk);
      chk(mtype, 2'h2);
      bus(1'b1, 4'hE, 32'h173); @(negedge clk);
      chk(mtype, 2'h3);
      bus(1'b1, 4'hE, 32'h170); @(negedge clk);
      chk(mtype, 2'h3);
      for (int c = 0; c < 8; c += 3) begin
         bus(1'b1, 4'hE, 32'h503 | (c << 4));
         @(negedge clk);
         chk({keep, pdly}, {1'b1, 3'(c)});
      end
      // auto repeat needs both bits
      bus(1'b1, 4'hE, 32'h17F); n_rst = 0; pulse(1);
      chk(n_rst, 1);
      bus(1'b1, 4'hE, 32'h177); n_rst = 0; pulse(1);
      chk(n_rst, 0);
      // phase steps: one per upper seed write, only without autoseed
      bus(1'b1, 4'hE, 32'h273); n_phs = 0;
      bus(1'b1, 4'hA, 32'h3FFFFFFF); bus(1'b1, 4'hA, 32'h1);
      repeat (4) @(posedge clk);
      chk(n_phs, 2);
      n_rld = 0; pulse(0); chk(n_rld, 0);
      bus(1'b1, 4'hE, 32'h373); n_phs = 0;
      bus(1'b1, 4'hA, 32'h5); repeat (4) @(posedge clk);
      chk(n_phs, 0);
      n_rld = 0; pulse(0); chk(n_rld, 1);
      // sweep mode with repeat control set, start without delay
      bus(1'b1, 4'hE, 32'h977); @(negedge clk);
      chk(swp, 1'b1);
      n_go = 0; pulse(2); chk(n_go, 1);
      // delayed start counts down the integer setpoint first
      bus(1'b1, 4'h5, 32'h28); bus(1'b1, 4'hE, 32'h9F7);
      n_go = 0; pulse(2); chk(n_go, 0);
      repeat (40) @(posedge clk);
      chk(n_go, 1);
      complete_run();
   end
endmodule : modulator_gpio_config_regs_bench
